// ### common/smbt_pkg.sv
// smbt_pkg: constants and carrier types for the smbus timeout block.
// assumes one 125 MHz clock and byte-wide registers on a plain port.
package smbt_pkg;

	localparam int unsigned ADDR_W = 16;
	localparam int unsigned DATA_W = 8;

	// register byte addresses
	localparam logic [ADDR_W-1:0] OFF_SMB      = 16'h3078;
	localparam logic [ADDR_W-1:0] OFF_A2       = 16'h3079;
	localparam logic [ADDR_W-1:0] OFF_SLTH     = 16'h307a;
	localparam logic [ADDR_W-1:0] OFF_SLTL     = 16'h307b;
	localparam logic [ADDR_W-1:0] OFF_INT_STAT = 16'h307c;
	localparam logic [ADDR_W-1:0] OFF_INT_MASK = 16'h307d;

	// smbus control/status field positions
	localparam int unsigned SMB_FACK     = 7;
	localparam int unsigned SMB_ALERTEN  = 6;
	localparam int unsigned SMB_SAEN     = 5;
	localparam int unsigned SMB_TIMEOUT_CLOCK_SELECT   = 4;
	localparam int unsigned SMB_LOWF     = 3;
	localparam int unsigned SMB_IDLEF    = 2;
	localparam int unsigned SMB_HLF      = 1;
	localparam int unsigned SMB_HLIE     = 0;

	// interrupt status / mask field positions
	localparam int unsigned INT_LOW      = 0;
	localparam int unsigned INT_HL       = 1;
	localparam int unsigned INT_IDLE     = 2;
	localparam int unsigned INT_W        = 3;

	// reset values
	localparam logic [7:0]        RST_SMB    = 8'h00;
	localparam logic [6:0]        RST_A2     = 7'h00;
	localparam logic [7:0]        RST_SLTH   = 8'h00;
	localparam logic [7:0]        RST_SLTL   = 8'h00;
	localparam logic [INT_W-1:0]  RST_INT    = 3'h0;
	localparam logic [DATA_W-1:0] RD_UNMAPPED = 8'h00;

	// timeout clocking
	localparam int unsigned TCK_DIV_RATIO = 64;
	localparam int unsigned TCK_DIV_W     = 6;
	localparam int unsigned HIGH_SHIFT    = 9;

	// detector slots
	localparam int unsigned DET_LOW  = 0;
	localparam int unsigned DET_IDLE = 1;
	localparam int unsigned DET_HL   = 2;
	localparam int unsigned NUM_DET  = 3;

	typedef struct packed {
		logic              wr;
		logic              rd;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} smbt_bus_req_t;

endpackage : smbt_pkg

// ### core/smbt_tick_gen.sv
// smbt_tick_gen: timeout counter tick, module clock or module clock / 64.
// assumes sys_clk is the module clock; tick is a one-cycle enable.
`timescale 1ns/1ps
module smbt_tick_gen
	import smbt_pkg::*;
(
	input  wire logic sys_clk,   // module clock
	input  wire logic rstn,      // async reset, active low
	input  wire logic fast_sel,  // 1: every clock, 0: every 64th
	output logic      tick       // one-cycle count enable
);
	import smbt_pkg::*;

	localparam logic [TCK_DIV_W-1:0] DIV_LAST = TCK_DIV_W'(TCK_DIV_RATIO - 1);

	logic [TCK_DIV_W-1:0] div_q;
	logic [TCK_DIV_W-1:0] div_d;
	logic                 tick_d;

	assign div_d  = (div_q == DIV_LAST) ? '0 : div_q + 1'b1;
	assign tick_d = fast_sel | (div_q == DIV_LAST);  // [RL1]

	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			div_q <= '0;
			tick  <= 1'b0;
		end
		else
		begin
			div_q <= div_d;
			tick  <= tick_d;
		end
	end

endmodule : smbt_tick_gen

// ### core/smbt_tmo_cnt.sv
// smbt_tmo_cnt: counts ticks while a bus condition holds.
// assumes cond and thr are synchronous; thr of zero disables expiry.
`timescale 1ns/1ps
module smbt_tmo_cnt
	import smbt_pkg::*;
(
	input  wire logic        sys_clk,  // module clock
	input  wire logic        rstn,     // async reset, active low
	input  wire logic        tick,     // count enable
	input  wire logic        cond,     // condition being timed
	input  wire logic [15:0] thr,      // ticks needed to expire
	output logic             expired   // condition held thr ticks
);
	import smbt_pkg::*;

	logic [15:0] cnt_q;
	logic [15:0] cnt_d;
	logic        reached;

	assign reached = (thr != 16'h0000) && (cnt_q >= thr);  // [RL4]
	// restart when condition drops, saturate once reached
	assign cnt_d   = !cond ? 16'h0000 :
	                 (tick && !reached) ? cnt_q + 16'h0001 : cnt_q;  // [RL14]
	assign expired = cond && reached;

	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
			cnt_q <= 16'h0000;
		else
			cnt_q <= cnt_d;
	end

endmodule : smbt_tmo_cnt

// ### core/smbt_timeout_core.sv
// smbt_timeout_core: smbus timeouts, flags, second slave address.
// assumes scl/sda and the register port are synchronous to sys_clk;
// the byte engine supplies received addresses for matching.
//
// Design decision made here: the strobed register port.
`timescale 1ns/1ps

// Notes on behaviour
// RL1: tick is clock/64, or clock when select set
// RL2: low flag sets when scl low reaches limit
// RL3: low flag clears on one write only
// RL4: zero limit disables scl low detection
// RL5: idle flag when both high over limit/512
// RL6: idle flag read-only, clears when idle ends
// RL7: high-low flag: scl high, sda low too long
// RL8: high-low flag clears on one write only
// RL9: enable bit gates high-low flag interrupt
// RL10: second address register holds 7-bit address
// RL11: second address bit 0 reads zero
// RL12: limit is high byte over low byte
// RL13: second address matches only when enabled
// RL14: counter restarts on scl high, counts while low
module smbt_timeout_core
	import smbt_pkg::*;
(
	input  wire logic              sys_clk,                  // module clock, 125 MHz
	input  wire logic              rstn,                     // async reset, active low
	input  wire smbt_pkg::smbt_bus_req_t bus_req,            // register strobes, addr, data
	output logic [smbt_pkg::DATA_W-1:0] rd_data_q,           // read data, cycle after rd
	input  wire logic              scl_in,                   // scl line level
	input  wire logic              sda_in,                   // sda line level
	input  wire logic              match_req,                // received address valid
	input  wire logic [6:0]        match_addr,               // received 7-bit address
	output logic                   second_addr_hit_q,        // pulse: second address hit
	output logic                   fast_ack_en_q,            // fast ack/nack enable
	output logic                   alert_en_q,               // alert response enable
	output logic                   low_timeout_flag_q,       // scl low timeout flag
	output logic                   bus_idle_timeout_flag_q,  // bus idle timeout flag
	output logic                   high_low_timeout_flag_q,  // scl high sda low flag
	output logic                   irq_q                     // level interrupt
);
	import smbt_pkg::*;

	// register state
	logic             fast_ack_en_d;
	logic             alert_en_d;
	logic             second_address_enable_q;
	logic             second_address_enable_d;
	logic             timeout_clock_select_q;
	logic             timeout_clock_select_d;
	logic             high_low_timeout_irq_enable_q;
	logic             high_low_timeout_irq_enable_d;
	logic             low_timeout_flag_d;
	logic             bus_idle_timeout_flag_d;
	logic             high_low_timeout_flag_d;
	logic [6:0]       default_slave_address_q;
	logic [6:0]       default_slave_address_d;
	logic [7:0]       limit_high_q;
	logic [7:0]       limit_high_d;
	logic [7:0]       limit_low_q;
	logic [7:0]       limit_low_d;
	logic [INT_W-1:0] int_stat_q;
	logic [INT_W-1:0] int_stat_d;
	logic [INT_W-1:0] int_mask_q;
	logic [INT_W-1:0] int_mask_d;
	logic [DATA_W-1:0] rd_data_d;
	logic             second_addr_hit_d;
	logic             irq_d;

	// address decode
	logic             sel_smb;
	logic             sel_a2;
	logic             sel_slth;
	logic             sel_sltl;
	logic             sel_stat;
	logic             sel_mask;
	logic             wr_smb;
	logic             wr_a2;
	logic             wr_slth;
	logic             wr_sltl;
	logic             wr_stat;
	logic             wr_mask;

	assign sel_smb  = (bus_req.addr == OFF_SMB);
	assign sel_a2   = (bus_req.addr == OFF_A2);
	assign sel_slth = (bus_req.addr == OFF_SLTH);
	assign sel_sltl = (bus_req.addr == OFF_SLTL);
	assign sel_stat = (bus_req.addr == OFF_INT_STAT);
	assign sel_mask = (bus_req.addr == OFF_INT_MASK);

	assign wr_smb   = bus_req.wr && sel_smb;
	assign wr_a2    = bus_req.wr && sel_a2;
	assign wr_slth  = bus_req.wr && sel_slth;
	assign wr_sltl  = bus_req.wr && sel_sltl;
	assign wr_stat  = bus_req.wr && sel_stat;
	assign wr_mask  = bus_req.wr && sel_mask;

	// timeout limit and detector thresholds
	logic [15:0]        low_timeout_limit;
	logic [15:0]        high_thr;
	logic [15:0]        det_thr  [NUM_DET];
	logic [NUM_DET-1:0] det_cond;
	logic [NUM_DET-1:0] det_exp;
	logic [NUM_DET-1:0] det_exp_q;
	logic [NUM_DET-1:0] det_rise;
	logic               tick;

	assign low_timeout_limit = {limit_high_q, limit_low_q};  // [RL12]
	// "more than" limit/512: one tick past the quotient
	assign high_thr = (low_timeout_limit >> HIGH_SHIFT) + 16'h0001;

	assign det_cond[DET_LOW]  = !scl_in;             // [RL14]
	assign det_cond[DET_IDLE] = scl_in && sda_in;    // [RL5]
	assign det_cond[DET_HL]   = scl_in && !sda_in;   // [RL7]
	assign det_thr[DET_LOW]   = low_timeout_limit;   // [RL4]
	assign det_thr[DET_IDLE]  = high_thr;
	assign det_thr[DET_HL]    = high_thr;
	assign det_rise           = det_exp & ~det_exp_q;

	smbt_tick_gen u_tick
	(
		.sys_clk  (sys_clk),
		.rstn     (rstn),
		.fast_sel (timeout_clock_select_q),  // [RL1]
		.tick     (tick)
	);

	genvar gi;
	generate
		for (gi = 0; gi < NUM_DET; gi++)
		begin : g_det
			smbt_tmo_cnt u_cnt
			(
				.sys_clk (sys_clk),
				.rstn    (rstn),
				.tick    (tick),
				.cond    (det_cond[gi]),
				.thr     (det_thr[gi]),
				.expired (det_exp[gi])
			);
		end
	endgenerate

	// control bits of the smbus register
	assign fast_ack_en_d = wr_smb ? bus_req.wdata[SMB_FACK] : fast_ack_en_q;
	assign alert_en_d    = wr_smb ? bus_req.wdata[SMB_ALERTEN] : alert_en_q;
	assign second_address_enable_d =
		wr_smb ? bus_req.wdata[SMB_SAEN] : second_address_enable_q;
	assign timeout_clock_select_d =
		wr_smb ? bus_req.wdata[SMB_TIMEOUT_CLOCK_SELECT] : timeout_clock_select_q;
	assign high_low_timeout_irq_enable_d =
		wr_smb ? bus_req.wdata[SMB_HLIE] : high_low_timeout_irq_enable_q;

	// sticky flags: set wins over a same-cycle clear
	assign low_timeout_flag_d = det_exp[DET_LOW] ||
		(low_timeout_flag_q && !(wr_smb && bus_req.wdata[SMB_LOWF]));  // [RL2] [RL3]
	assign high_low_timeout_flag_d = det_exp[DET_HL] ||
		(high_low_timeout_flag_q && !(wr_smb && bus_req.wdata[SMB_HLF]));  // [RL7] [RL8]
	// idle flag follows the condition, no write path
	assign bus_idle_timeout_flag_d = det_exp[DET_IDLE];  // [RL5] [RL6]

	// second address and limit bytes
	assign default_slave_address_d =
		wr_a2 ? bus_req.wdata[7:1] : default_slave_address_q;  // [RL10]
	assign limit_high_d = wr_slth ? bus_req.wdata : limit_high_q;
	assign limit_low_d  = wr_sltl ? bus_req.wdata : limit_low_q;

	// interrupt status: events set, write one clears, set wins
	logic [INT_W-1:0] int_event;
	logic [INT_W-1:0] int_clr;

	assign int_event[INT_LOW]  = det_rise[DET_LOW];
	assign int_event[INT_HL]   = det_rise[DET_HL];
	assign int_event[INT_IDLE] = det_rise[DET_IDLE];
	assign int_clr    = wr_stat ? bus_req.wdata[INT_W-1:0] : '0;
	assign int_stat_d = int_event | (int_stat_q & ~int_clr);
	assign int_mask_d = wr_mask ? bus_req.wdata[INT_W-1:0] : int_mask_q;

	// interrupt: masked status plus the high-low flag enable
	assign irq_d = (|(int_stat_q & int_mask_q)) ||
		(high_low_timeout_flag_q && high_low_timeout_irq_enable_q);  // [RL9]

	// second address match
	assign second_addr_hit_d = match_req && second_address_enable_q &&
		(match_addr == default_slave_address_q);  // [RL13]

	// read data mux
	logic [DATA_W-1:0] smb_view;

	assign smb_view = {fast_ack_en_q, alert_en_q, second_address_enable_q,
		timeout_clock_select_q, low_timeout_flag_q, bus_idle_timeout_flag_q,
		high_low_timeout_flag_q, high_low_timeout_irq_enable_q};

	assign rd_data_d = !bus_req.rd ? RD_UNMAPPED :
		sel_smb  ? smb_view :
		sel_a2   ? {default_slave_address_q, 1'b0} :  // [RL11]
		sel_slth ? limit_high_q :
		sel_sltl ? limit_low_q :
		sel_stat ? {{(DATA_W-INT_W){1'b0}}, int_stat_q} :
		sel_mask ? {{(DATA_W-INT_W){1'b0}}, int_mask_q} :
		RD_UNMAPPED;

	// smbus control register
	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			fast_ack_en_q                 <= RST_SMB[SMB_FACK];
			alert_en_q                    <= RST_SMB[SMB_ALERTEN];
			second_address_enable_q       <= RST_SMB[SMB_SAEN];
			timeout_clock_select_q        <= RST_SMB[SMB_TIMEOUT_CLOCK_SELECT];
			high_low_timeout_irq_enable_q <= RST_SMB[SMB_HLIE];
		end
		else
		begin
			fast_ack_en_q                 <= fast_ack_en_d;
			alert_en_q                    <= alert_en_d;
			second_address_enable_q       <= second_address_enable_d;
			timeout_clock_select_q        <= timeout_clock_select_d;
			high_low_timeout_irq_enable_q <= high_low_timeout_irq_enable_d;
		end
	end

	// timeout flags
	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			low_timeout_flag_q      <= RST_SMB[SMB_LOWF];
			bus_idle_timeout_flag_q <= RST_SMB[SMB_IDLEF];
			high_low_timeout_flag_q <= RST_SMB[SMB_HLF];
			det_exp_q               <= '0;
		end
		else
		begin
			low_timeout_flag_q      <= low_timeout_flag_d;
			bus_idle_timeout_flag_q <= bus_idle_timeout_flag_d;
			high_low_timeout_flag_q <= high_low_timeout_flag_d;
			det_exp_q               <= det_exp;
		end
	end

	// address and limit bytes
	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			default_slave_address_q <= RST_A2;
			limit_high_q            <= RST_SLTH;
			limit_low_q             <= RST_SLTL;
		end
		else
		begin
			default_slave_address_q <= default_slave_address_d;
			limit_high_q            <= limit_high_d;
			limit_low_q             <= limit_low_d;
		end
	end

	// interrupt registers
	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			int_stat_q <= RST_INT;
			int_mask_q <= RST_INT;
			irq_q      <= 1'b0;
		end
		else
		begin
			int_stat_q <= int_stat_d;
			int_mask_q <= int_mask_d;
			irq_q      <= irq_d;
		end
	end

	// bus answer and match pulse
	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			rd_data_q         <= RD_UNMAPPED;
			second_addr_hit_q <= 1'b0;
		end
		else
		begin
			rd_data_q         <= rd_data_d;
			second_addr_hit_q <= second_addr_hit_d;
		end
	end

endmodule : smbt_timeout_core

// ### verif/smbt_line_model.sv
// smbt_line_model: far-side bus agent that pulls scl or sda low on demand.
// assumes open-drain lines with pull-ups, so a released line reads high.
`timescale 1ns/1ps
module smbt_line_model (
	input  wire logic sys_clk,   // module clock
	input  wire logic scl_hold,  // pull scl low
	input  wire logic sda_hold,  // pull sda low
	output logic      scl,       // scl line level
	output logic      sda        // sda line level
);
	// released lines go to the pull-up level
	always_ff @(posedge sys_clk)
	begin
		scl <= !scl_hold;
		sda <= !sda_hold;
	end
endmodule : smbt_line_model

// ### verif/smbt_timeout_core_chk.sv
// smbt_core_chk: port-level assertions for the smbus timeout core.
// assumes one clock; register contents are shadowed from bus writes.
`timescale 1ns/1ps
module smbt_core_chk
	import smbt_pkg::*;
(
	input wire logic                   sys_clk,                 // clock
	input wire logic                   rstn,                    // reset
	input wire smbt_pkg::smbt_bus_req_t bus_req,                // register port
	input wire logic [7:0]             rd_data_q,               // read data
	input wire logic                   scl_in,                  // scl level
	input wire logic                   sda_in,                  // sda level
	input wire logic                   match_req,               // address valid
	input wire logic [6:0]             match_addr,              // address
	input wire logic                   second_addr_hit_q,       // address hit
	input wire logic                   low_timeout_flag_q,      // low flag
	input wire logic                   bus_idle_timeout_flag_q, // idle flag
	input wire logic                   high_low_timeout_flag_q, // high-low flag
	input wire logic                   irq_q                    // interrupt
);
	logic        fast_q, hlie_q, saen_q;
	logic [15:0] lim_q, low_run_q;
	logic [2:0]  mask_q;
	logic [6:0]  a2_q;
	wire wr_smb = bus_req.wr && bus_req.addr == OFF_SMB;
	wire wr_a2 = bus_req.wr && bus_req.addr == OFF_A2;
	wire wr_lh = bus_req.wr && bus_req.addr == OFF_SLTH;
	wire wr_ll = bus_req.wr && bus_req.addr == OFF_SLTL;
	wire wr_mk = bus_req.wr && bus_req.addr == OFF_INT_MASK;
	wire hit_exp = saen_q && match_addr == a2_q;
	wire [7:0] a2_rd = {a2_q, 1'b0};
	wire low_due = fast_q && lim_q != 16'h0000 && !scl_in && low_run_q + 16'h0001 == lim_q;
	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
			{fast_q, hlie_q, saen_q, lim_q, low_run_q, mask_q, a2_q} <= '0;
		else
		begin
			if (wr_smb)
				{saen_q, fast_q, hlie_q} <= {bus_req.wdata[5:4], bus_req.wdata[0]};
			if (wr_a2)
				a2_q <= bus_req.wdata[7:1];
			if (wr_lh)
				lim_q[15:8] <= bus_req.wdata;
			if (wr_ll)
				lim_q[7:0] <= bus_req.wdata;
			if (wr_mk)
				mask_q <= bus_req.wdata[2:0];
			low_run_q <= (scl_in || !fast_q) ? 16'h0000 : low_run_q + 16'h0001;
		end
	end
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rstn);
	rd_quiet_a: assert property (!bus_req.rd |=> rd_data_q == 8'h00)
		else $error("read data not zero");
	a2_read_a: assert property (
		bus_req.rd && bus_req.addr == OFF_A2 |=> rd_data_q == $past(a2_rd))
		else $error("second address read wrong");
	low_due_a: assert property (low_due |-> ##[1:2] low_timeout_flag_q)
		else $error("low flag late");
	low_cause_a: assert property (
		$rose(low_timeout_flag_q) |-> !$past(scl_in, 2) && $past(lim_q, 2) != 16'h0000)
		else $error("low flag without cause");
	low_keep_a: assert property (
		low_timeout_flag_q && wr_smb && !bus_req.wdata[3] |=> low_timeout_flag_q)
		else $error("low flag lost");
	low_clear_a: assert property (
		wr_smb && bus_req.wdata[3] && scl_in && $past(scl_in) |=> !low_timeout_flag_q)
		else $error("low flag not cleared");
	hl_keep_a: assert property (
		high_low_timeout_flag_q && wr_smb && !bus_req.wdata[1] |=> high_low_timeout_flag_q)
		else $error("high-low flag lost");
	idle_drop_a: assert property (!(scl_in && sda_in) |=> !bus_idle_timeout_flag_q)
		else $error("idle flag stuck");
	hl_irq_a: assert property (high_low_timeout_flag_q && hlie_q |=> irq_q)
		else $error("high-low interrupt missing");
	irq_quiet_a: assert property (mask_q == 3'h0 && !hlie_q |=> !irq_q)
		else $error("interrupt while all masked");
	addr_hit_a: assert property (match_req |=> second_addr_hit_q == $past(hit_exp))
		else $error("second address hit wrong");
endmodule : smbt_core_chk

bind smbt_timeout_core smbt_core_chk chk (.sys_clk(sys_clk), .rstn(rstn), .bus_req(bus_req),
	.rd_data_q(rd_data_q), .scl_in(scl_in), .sda_in(sda_in), .match_req(match_req),
	.match_addr(match_addr), .second_addr_hit_q(second_addr_hit_q),
	.low_timeout_flag_q(low_timeout_flag_q), .bus_idle_timeout_flag_q(bus_idle_timeout_flag_q),
	.high_low_timeout_flag_q(high_low_timeout_flag_q), .irq_q(irq_q));

// ### verif/smbt_timeout_core_bench.sv
// smbt_timeout_core_bench: register and timeout sequences on the core.
// assumes the line model as far side and the bound checker.
`timescale 1ns/1ps
module smbt_timeout_core_bench;
	import smbt_pkg::*;
	logic          sys_clk = 1'b0;
	logic          rstn = 1'b0;
	smbt_bus_req_t bus_req = '0;
	logic          scl_hold = 1'b1;
	logic          sda_hold = 1'b0;
	logic          match_req = 1'b0;
	logic [6:0]    match_addr = 7'h00;
	logic          scl_in, sda_in, hit, lowf, idlef, hlf, irq, fack, alert;
	logic [7:0]    rd_data_q;
	logic [15:0]   offs [7] = '{OFF_SMB, OFF_A2, OFF_SLTH, OFF_SLTL, OFF_INT_STAT,
		OFF_INT_MASK, 16'h3077};
	int            n_errors = 0;
	int            checked = 0;
	always #4 sys_clk = ~sys_clk;
	smbt_line_model bus (.sys_clk(sys_clk), .scl_hold(scl_hold), .sda_hold(sda_hold),
		.scl(scl_in), .sda(sda_in));
	smbt_timeout_core uut (.sys_clk(sys_clk), .rstn(rstn), .bus_req(bus_req),
		.rd_data_q(rd_data_q), .scl_in(scl_in), .sda_in(sda_in), .match_req(match_req),
		.match_addr(match_addr), .second_addr_hit_q(hit), .fast_ack_en_q(fack),
		.alert_en_q(alert),
		.low_timeout_flag_q(lowf), .bus_idle_timeout_flag_q(idlef),
		.high_low_timeout_flag_q(hlf), .irq_q(irq));
	task chk(input logic [7:0] seen, input logic [7:0] exp);
		checked++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task cyc(input int n);
		bus_req <= '0;
		repeat (n) @(posedge sys_clk);
		#1;
	endtask : cyc
	task wr(input logic [15:0] a, input logic [7:0] d);
		bus_req <= '{1'b1, 1'b0, a, d};
		@(posedge sys_clk);
		#1;
	endtask : wr
	// m hides bits that move on their own
	task rd(input logic [15:0] a, input logic [7:0] e, input logic [7:0] m = 8'hff);
		bus_req <= '{1'b0, 1'b1, a, 8'h00};
		@(posedge sys_clk);
		#1;
		chk(rd_data_q & m, e);
	endtask : rd
	task end_of_test;
		$display("TB: errors %0d checks %0d", n_errors, checked);
		if (n_errors == 0 && checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : end_of_test
	initial
	begin
		#8000;
		n_errors++;
		end_of_test();
	end
	initial
	begin
		repeat (2) @(posedge sys_clk);
		rstn <= 1'b1;
		@(posedge sys_clk);
		#1;
		foreach (offs[i])
			rd(offs[i], 8'h00);
		wr(OFF_SMB, 8'h10);
		cyc(20);
		chk(8'(lowf), 8'h00);
		scl_hold <= 1'b0;
		wr(OFF_A2, 8'hff);
		rd(OFF_A2, 8'hfe);
		wr(OFF_SLTH, 8'h12);
		wr(OFF_SLTL, 8'h34);
		rd(OFF_SLTH, 8'h12);
		rd(OFF_SLTL, 8'h34);
		wr(OFF_SLTH, 8'h00);
		wr(OFF_SLTL, 8'h03);
		repeat (2)
		begin
			scl_hold <= 1'b1;
			cyc(2);
			scl_hold <= 1'b0;
			cyc(2);
		end
		chk(8'(lowf), 8'h00);
		scl_hold <= 1'b1;
		cyc(3);
		chk(8'(lowf), 8'h00);
		cyc(3);
		chk(8'(lowf), 8'h01);
		rd(OFF_SMB, 8'h18, 8'hfb);
		rd(OFF_INT_STAT, 8'h01, 8'h03);
		wr(OFF_INT_MASK, 8'h01);
		cyc(1);
		chk(8'(irq), 8'h01);
		wr(OFF_SMB, 8'h10);
		rd(OFF_SMB, 8'h18, 8'hfb);
		scl_hold <= 1'b0;
		cyc(3);
		wr(OFF_SMB, 8'h18);
		rd(OFF_SMB, 8'h10, 8'hfb);
		wr(OFF_INT_STAT, 8'h07);
		cyc(1);
		chk(8'(irq), 8'h00);
		wr(OFF_SLTH, 8'h04);
		wr(OFF_SLTL, 8'h00);
		sda_hold <= 1'b1;
		cyc(3);
		chk(8'(idlef), 8'h00);
		chk(8'(hlf), 8'h00);
		cyc(3);
		chk(8'(hlf), 8'h01);
		chk(8'(irq), 8'h00);
		rd(OFF_INT_STAT, 8'h02);
		wr(OFF_SMB, 8'h15);
		cyc(1);
		chk(8'(irq), 8'h01);
		rd(OFF_SMB, 8'h13);
		wr(OFF_SMB, 8'h10);
		cyc(1);
		chk(8'(irq), 8'h00);
		sda_hold <= 1'b0;
		cyc(2);
		chk(8'(idlef), 8'h00);
		wr(OFF_SMB, 8'h12);
		cyc(8);
		chk(8'(hlf), 8'h00);
		chk(8'(idlef), 8'h01);
		wr(OFF_SMB, 8'h00);
		wr(OFF_SLTH, 8'h00);
		wr(OFF_SLTL, 8'h03);
		scl_hold <= 1'b1;
		cyc(120);
		chk(8'(lowf), 8'h00);
		cyc(80);
		chk(8'(lowf), 8'h01);
		scl_hold <= 1'b0;
		cyc(3);
		wr(OFF_SMB, 8'hc8);
		rd(OFF_SMB, 8'hc0, 8'hfb);
		chk({6'h00, fack, alert}, 8'h03);
		for (int i = 0; i < 3; i++)
		begin
			wr(OFF_SMB, (i > 0) ? 8'h20 : 8'h00);
			match_addr <= (i == 2) ? 7'h7e : 7'h7f;
			match_req <= 1'b1;
			cyc(1);
			match_req <= 1'b0;
			chk(8'(hit), (i == 1) ? 8'h01 : 8'h00);
		end
		end_of_test();
	end
endmodule : smbt_timeout_core_bench
